// *** tb/pie_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
module pie_asserts #(
  parameter bit UART_VARIANT = 1'b0
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire pie_pkg::pie_src_type FLAGS,
  input wire pie_pkg::pie_src_type SRC_REQ,
  input wire logic CORE_IRQ
);
  wire logic wr = PSEL && PENABLE && PREADY && PWRITE;
  wire logic wen = wr && PADDR == pie_pkg::ADDR_ENABLE;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  property p_rst; $fell(RST) |-> !CORE_IRQ && SRC_REQ == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("rst");
  property p_hi; SRC_REQ[7:6] == 2'h0 && (UART_VARIANT || SRC_REQ[5:4] == 2'h0); endproperty
  a_hi: assert property (p_hi) else $error("hi");
  property p_flg; (SRC_REQ & ~$past(FLAGS)) == 8'h00; endproperty
  a_flg: assert property (p_flg) else $error("flg");
  property p_irq; CORE_IRQ == (SRC_REQ != 8'h00); endproperty
  a_irq: assert property (p_irq) else $error("irq");
  property p_grp; wr && PADDR == pie_pkg::ADDR_CONTROL && PWDATA[7:6] != 2'h3 |=> ##1 SRC_REQ == 8'h00; endproperty
  a_grp: assert property (p_grp) else $error("grp");
  property p_e3; wen && !PWDATA[3] |=> ##1 !SRC_REQ[3]; endproperty
  a_e3: assert property (p_e3) else $error("e3");
  property p_e1; wen && !PWDATA[1] |=> ##1 !SRC_REQ[1]; endproperty
  a_e1: assert property (p_e1) else $error("e1");
  property p_e0; wen && !PWDATA[0] |=> ##1 !SRC_REQ[0]; endproperty
  a_e0: assert property (p_e0) else $error("e0");
  property p_e2; wen && !PWDATA[2] |=> ##1 !SRC_REQ[2]; endproperty
  a_e2: assert property (p_e2) else $error("e2");
  property p_e4; wen && !PWDATA[4] |=> ##1 !SRC_REQ[4]; endproperty
  a_e4: assert property (p_e4) else $error("e4");
  property p_e5; wen && !PWDATA[5] |=> ##1 !SRC_REQ[5]; endproperty
  a_e5: assert property (p_e5) else $error("e5");
  c_wen: cover property (wen);
  c_irq: cover property (CORE_IRQ);
  c_req: cover property (SRC_REQ[3]);
endmodule
bind pie_top pie_asserts #(.UART_VARIANT(UART_VARIANT)) i_chk (.CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR,
  .PWDATA, .PREADY, .FLAGS, .SRC_REQ, .CORE_IRQ);
`default_nettype wire

// *** tb/pie_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module pie_tb_top;
  logic CLK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [11:0] PADDR = '0;
  logic [31:0] PWDATA = '0, PRDATA;
  logic PREADY, PSLVERR, CORE_IRQ, IRQ;
  pie_pkg::pie_src_type FLAGS = '0, SRC_REQ;
  pie_pkg::pie_src_type SRC_REQ_U;
  logic CORE_IRQ_U;
  logic [32:0] q[$];
  logic [7:0] en, f, st = 8'h00;
  int fails = 0, n_compared = 0;
  pie_top i_dut (.CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB(4'hf), .PRDATA, .PREADY,
    .PSLVERR, .FLAGS, .SRC_REQ, .CORE_IRQ, .IRQ);
  // UART variant shares the bus and flags; its requests are checked directly
  pie_top #(.UART_VARIANT(1'b1)) i_dut_uart (.CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
    .PSTRB(4'hf), .PRDATA(), .PREADY(), .PSLVERR(), .FLAGS, .SRC_REQ(SRC_REQ_U), .CORE_IRQ(CORE_IRQ_U), .IRQ());
  task automatic chk(logic [32:0] a, logic [32:0] e);
    n_compared++;
    if (a !== e) begin
      fails++;
      $display("mismatch %0t %h %h", $time, a, e);
    end
  endtask
  task automatic report_and_stop();
    $display("%0d compared %0d fails", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic xfer(logic w, logic [11:0] a, logic [7:0] d, logic [32:0] e);
    if (!w)
      q.push_back(e);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= {24'h0, d};
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    for (int n = 0; !PREADY && n < 20; n++)
      @(posedge CLK);
    if (!PREADY) begin
      fails++;
      $display("mismatch %0t no ready", $time);
      report_and_stop();
    end
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask
  // Read results are matched in order of issue
  always @(posedge CLK)
    if (PSEL && PENABLE && PREADY && !PWRITE)
      chk({PSLVERR, PRDATA}, q.pop_front());
  initial forever #12.5 CLK = ~CLK;
  initial begin
    void'($urandom(92459));
    repeat (20) @(posedge CLK);
    RST <= 1'b0;
    xfer(0, 12'h08c, 8'h00, 33'h0);
    xfer(1, 12'h08c, 8'h3f, 33'h0);
    xfer(0, 12'h08c, 8'h00, 33'h0f);
    xfer(0, 12'h0a0, 8'h00, {1'b1, 32'h0});
    for (int i = 0; i < 12; i++) begin
      en = 8'($urandom) & 8'h3f;
      f = 8'($urandom);
      st |= f & ~FLAGS & 8'h0f;
      FLAGS <= f;
      xfer(1, 12'h08c, en, 33'h0);
      xfer(1, 12'h088, i < 4 ? {i[1:0], 6'h0} : 8'hc0, 33'h0);
      xfer(0, 12'h098, 8'h00, {25'h0, i < 3 ? 8'h00 : f & en & 8'h0f});
      chk({32'h0, CORE_IRQ}, {32'h0, i >= 3 && (f & en & 8'h0f) != 8'h00});
      chk({25'h0, SRC_REQ_U}, {25'h0, i < 3 ? 8'h00 : f & en & 8'h3f});
      chk({32'h0, CORE_IRQ_U}, {32'h0, i >= 3 && (f & en & 8'h3f) != 8'h00});
      chk({32'h0, IRQ}, 33'h0);
    end
    FLAGS <= '0;
    xfer(0, 12'h090, 8'h00, {25'h0, st});
    xfer(1, 12'h094, 8'h0f, 33'h0);
    FLAGS <= 8'h04;
    repeat (3) @(posedge CLK);
    chk({32'h0, IRQ}, 33'h1);
    xfer(0, 12'h090, 8'h00, 33'h4);
    @(posedge CLK);
    chk({32'h0, IRQ}, 33'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire

// *** verilog/pie_evt_bank.sv ***
`timescale 1ns/10ps
`default_nettype none
module pie_evt_bank #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] src_en,
  input wire logic [WIDTH-1:0] level,
  input wire logic [WIDTH-1:0] clear,
  output logic [WIDTH-1:0] status_q
);
  logic [WIDTH-1:0] level_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      level_q <= '0;
    end else begin
      level_q <= level;
    end
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // Rising flag edge sets the bit; a set in the clearing cycle wins
      always_ff @(posedge clk) begin
        if (rst) begin
          status_q[i] <= 1'b0;
        end else if (src_en[i] && level[i] && !level_q[i]) begin
          status_q[i] <= 1'b1;
        end else if (clear[i]) begin
          status_q[i] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// *** verilog/pie_pkg.sv ***
// Summary of operation
// - No peripheral request reaches the core unless the group enable is set.
// - Without a UART, enable bits five and four ignore writes, read zero.
// - Enable bit three passes or blocks the serial port interrupt.
// - Enable bit two passes or blocks the capture/compare one interrupt.
// - Enable bit one passes or blocks the timer two period match interrupt.
// - Enable bit zero passes or blocks the timer one overflow interrupt.
// - With a UART, a writable enable bit gates the UART receive interrupt.
// - With a UART, enable bit four gates the UART transmit interrupt.
// - Reset clears every implemented enable bit, so all sources start disabled.
// - Flags are set by their condition, regardless of any enable bit.
// - A clear global enable blocks every peripheral request to the core.
`default_nettype none
package pie_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned REG_W = 8;

  // Byte addresses on the register bus
  localparam logic [11:0] ADDR_CONTROL = 12'h088;
  localparam logic [11:0] ADDR_ENABLE = 12'h08c;
  localparam logic [11:0] ADDR_EVT_STATUS = 12'h090;
  localparam logic [11:0] ADDR_EVT_MASK = 12'h094;
  localparam logic [11:0] ADDR_REQUEST = 12'h098;

  // Control register field positions
  localparam int unsigned BIT_GLOBAL = 7;
  localparam int unsigned BIT_GROUP = 6;

  // Enable register field positions
  localparam int unsigned BIT_UART_RX = 5;
  localparam int unsigned BIT_UART_TX = 4;

  // Writable enable bits per variant
  localparam logic [7:0] ENABLE_WMASK_BASIC = 8'hcf;
  localparam logic [7:0] ENABLE_WMASK_UART = 8'hff;
  // Sources that raise events (reserved bits never do)
  localparam logic [7:0] SRC_MASK_BASIC = 8'h0f;
  localparam logic [7:0] SRC_MASK_UART = 8'h3f;

  localparam logic [7:0] RESET_ENABLE = 8'h00;
  localparam logic [7:0] RESET_CONTROL = 8'h00;
  localparam logic [7:0] RESET_MASK = 8'h00;

  // One bit per enable register position
  typedef struct packed {
    logic [1:0] reserved;
    logic uart_receive;
    logic uart_transmit;
    logic serial_port;
    logic capcomp1;
    logic timer2_match;
    logic timer1_overflow;
  } pie_src_type;

  typedef struct packed {
    logic global_irq_enable;
    logic peripheral_group_enable;
  } pie_ctrl_type;
endpackage
`default_nettype wire

// *** verilog/pie_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module pie_top #(
  parameter bit UART_VARIANT = 1'b0
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire pie_pkg::pie_src_type FLAGS,
  output pie_pkg::pie_src_type SRC_REQ,
  output logic CORE_IRQ,
  output logic IRQ
);
  localparam logic [7:0] ENABLE_WMASK = UART_VARIANT ? pie_pkg::ENABLE_WMASK_UART : pie_pkg::ENABLE_WMASK_BASIC;
  localparam logic [7:0] SRC_MASK = UART_VARIANT ? pie_pkg::SRC_MASK_UART : pie_pkg::SRC_MASK_BASIC;

  pie_pkg::pie_src_type enable_q;
  pie_pkg::pie_ctrl_type ctrl_q;
  logic [7:0] evt_mask_q;
  logic [7:0] evt_status;
  logic [7:0] evt_clear;
  logic [7:0] gated;
  logic setup_phase;
  logic access_done;
  logic wr_done;
  logic rd_done;
  logic addr_ok;
  logic [7:0] rd_byte;
  logic byte0_wr;
  logic [7:0] wdata8;

  assign setup_phase = PSEL && !PENABLE;
  assign access_done = PSEL && PENABLE && PREADY;
  assign wr_done = access_done && PWRITE && !PSLVERR;
  assign rd_done = access_done && !PWRITE && !PSLVERR;
  assign byte0_wr = wr_done && PSTRB[0];
  assign wdata8 = PWDATA[7:0];

  always_comb begin
    addr_ok = 1'b1;
    rd_byte = 8'h00;
    unique case (PADDR)
      pie_pkg::ADDR_CONTROL: begin
        rd_byte[pie_pkg::BIT_GLOBAL] = ctrl_q.global_irq_enable;
        rd_byte[pie_pkg::BIT_GROUP] = ctrl_q.peripheral_group_enable;
      end
      pie_pkg::ADDR_ENABLE: begin
        rd_byte = enable_q & ENABLE_WMASK;
      end
      pie_pkg::ADDR_EVT_STATUS: begin
        rd_byte = evt_status;
      end
      pie_pkg::ADDR_EVT_MASK: begin
        rd_byte = evt_mask_q;
      end
      pie_pkg::ADDR_REQUEST: begin
        rd_byte = SRC_REQ;
      end
      default: begin
        addr_ok = 1'b0;
      end
    endcase
  end

  // Zero wait state slave: ready one cycle after setup
  always_ff @(posedge CLK) begin
    if (RST) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
    end else begin
      PREADY <= setup_phase;
      if (setup_phase) begin
        PSLVERR <= !addr_ok;
        PRDATA <= (addr_ok && !PWRITE) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end else if (access_done) begin
        PSLVERR <= 1'b0;
      end
    end
  end

  // Enable register; reserved top bits are stored as written
  always_ff @(posedge CLK) begin
    if (RST) begin
      enable_q <= pie_pkg::RESET_ENABLE;
    end else if (byte0_wr && PADDR == pie_pkg::ADDR_ENABLE) begin
      enable_q <= wdata8 & ENABLE_WMASK;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      ctrl_q <= pie_pkg::RESET_CONTROL[1:0];
    end else if (byte0_wr && PADDR == pie_pkg::ADDR_CONTROL) begin
      ctrl_q.global_irq_enable <= wdata8[pie_pkg::BIT_GLOBAL];
      ctrl_q.peripheral_group_enable <= wdata8[pie_pkg::BIT_GROUP];
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      evt_mask_q <= pie_pkg::RESET_MASK;
    end else if (byte0_wr && PADDR == pie_pkg::ADDR_EVT_MASK) begin
      evt_mask_q <= wdata8 & SRC_MASK;
    end
  end

  // Each bit gates its own source: 0 timer1, 1 timer2, 2 capture_compare_one, 3 ssp, 4 tx, 5 rx
  assign gated = FLAGS & enable_q & SRC_MASK;

  always_ff @(posedge CLK) begin
    if (RST) begin
      SRC_REQ <= '0;
      CORE_IRQ <= 1'b0;
    end else begin
      if (ctrl_q.global_irq_enable && ctrl_q.peripheral_group_enable) begin
        SRC_REQ <= gated;
        CORE_IRQ <= |gated;
      end else begin
        SRC_REQ <= '0;
        CORE_IRQ <= 1'b0;
      end
    end
  end

  // Clear only the bits the read reported, so an event landing at the setup edge survives
  assign evt_clear = (rd_done && PADDR == pie_pkg::ADDR_EVT_STATUS) ? PRDATA[7:0] : 8'h00;

  // Events follow the raw flags, not the enables
  pie_evt_bank #(
    .WIDTH(pie_pkg::REG_W)
  ) u_evt (
    .clk(CLK),
    .rst(RST),
    .src_en(SRC_MASK),
    .level(FLAGS),
    .clear(evt_clear),
    .status_q(evt_status)
  );

  always_ff @(posedge CLK) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(evt_status & evt_mask_q);
    end
  end
endmodule
`default_nettype wire
